/* rtl/pfs_top.sv */
// pin function select multiplexer with reset pin qualifier and memory map decode
`timescale 1ns/1ps
`default_nettype none

module pfs_top
  import pfs_pkg::*;
#(
  parameter int unsigned RST_HOLD_CYCLES = RST_HOLD_CYC
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // register port
  input  wire pfs_bus_req_t bus_req,
  output logic [7:0]        bus_rdata,
  // pads: 0..5 are P2.0..P2.5, 6 is P9.1, 7 is P9.2
  input  wire logic [7:0]   pad_i,
  output logic [7:0]        pad_o,
  output logic [7:0]        pad_oe,
  // external reset pin and qualified system reset
  input  wire logic         reset_active_low,
  output logic              sys_rst_b,
  // peripheral side
  input  wire pfs_per_out_t per_o,
  output var pfs_per_in_t   per_i,
  // memory map lookup
  input  wire pfs_space_t   mem_space,
  input  wire logic [15:0]  mem_addr,
  output pfs_region_t       mem_region
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] pfs_reg_idx(input logic sfr, input logic [15:0] a);
    logic [3:0] r;
    r = RI_NONE;
    if (sfr) begin
      if (a[15:8] == 8'h00 && a[7:0] == ADR_PORT9_FUNCTION_SELECT) r = RI_P9;
    end else if (a == ADR_PROTECTION_CONTROL_ZERO) begin
      r = RI_PROT;
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (a == ADR_PORT2_FUNCTION_SELECT[k]) r = RI_P2_0 + 4'(k);
      end
    end
    return r;
  endfunction : pfs_reg_idx

  function automatic pfs_region_t pfs_region(input pfs_space_t sp, input logic [15:0] a);
    pfs_region_t r;
    r = RG_NONE;
    case (sp)
      SP_DIRECT: begin
        if (a <= 16'(IRAM_BYTES - 1)) r = (a <= 16'(IRAM_LO - 1)) ? RG_IRAM_LO : RG_SFR; // RQ12
      end
      SP_INDIRECT: begin
        if (a <= 16'(IRAM_BYTES - 1)) r = (a <= 16'(IRAM_LO - 1)) ? RG_IRAM_LO : RG_IRAM_HI; // RQ12
      end
      SP_XDATA: r = (a <= 16'(XRAM_BYTES - 1)) ? RG_XRAM : RG_PERIPH; // RQ13
      SP_CODE:  r = (a <= 16'(CODE_BYTES - 1)) ? RG_CODE : RG_NONE; // RQ14
      default:  r = RG_NONE;
    endcase
    return r;
  endfunction : pfs_region

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pfs_state_t      st;
  pfs_state_t      st_nxt;
  logic [3:0]      idx;
  logic [7:0][1:0] fnv;
  logic            scal;

  always_comb begin
    st_nxt = st;
    idx    = pfs_reg_idx(bus_req.sfr, bus_req.addr);
    scal   = st.protection_control_zero[PROT_SCAL_EN_BIT];
    fnv    = '0;

    // register writes
    if (bus_req.wr) begin
      if (idx == RI_P9) begin
        st_nxt.port9_function_select = bus_req.wdata;
      end else if (idx == RI_PROT) begin
        st_nxt.protection_control_zero = bus_req.wdata;
      end else if (idx != RI_NONE) begin
        st_nxt.port2_function_select[3'(idx - RI_P2_0)] = bus_req.wdata;
      end
    end

    // read data stand for exactly one cycle
    st_nxt.rdata = 8'h00;
    if (bus_req.rd) begin
      if (idx == RI_P9) begin
        st_nxt.rdata = st.port9_function_select;
      end else if (idx == RI_PROT) begin
        st_nxt.rdata = st.protection_control_zero;
      end else if (idx != RI_NONE) begin
        st_nxt.rdata = st.port2_function_select[3'(idx - RI_P2_0)];
      end
    end

    // three-stage pin sync; a level counts once stages two and three agree
    st_nxt.sy1 = {reset_active_low, pad_i};
    st_nxt.sy2 = st.sy1;
    st_nxt.sy3 = st.sy2;
    for (int i = 0; i < 9; i++) begin
      if (st.sy2[i] == st.sy3[i]) st_nxt.flt[i] = st.sy3[i];
    end

    // reset pin qualifier: short glitches never reach the system
    if (st.flt[8]) begin
      st_nxt.rcnt = '0;
      st_nxt.srst = 1'b0;
    end else if (st.rcnt == 17'(RST_HOLD_CYCLES - 1)) begin
      st_nxt.srst = 1'b1; // RQ11
    end else begin
      st_nxt.rcnt = st.rcnt + 17'h00001;
    end

    // free-running carrier for infrared transmit
    if (st.ccnt == 9'(CAR_HALF - 1)) begin
      st_nxt.ccnt = '0;
      st_nxt.car  = ~st.car;
    end else begin
      st_nxt.ccnt = st.ccnt + 9'h001;
    end

    // function code per pad
    for (int i = 0; i < 6; i++) begin
      fnv[i] = st.port2_function_select[i][FS_FN_LSB +: 2];
    end
    fnv[6] = st.port9_function_select[P9_PIN1_LSB +: 2];
    fnv[7] = st.port9_function_select[P9_PIN2_LSB +: 2];

    // gpio by default; unrouted peripheral inputs sit idle
    st_nxt.pin = PIN_IDLE; // RQ15
    for (int i = 0; i < 8; i++) begin
      if (fnv[i] == FN_GPIO && !(scal && i >= 6)) begin
        st_nxt.po[i]         = per_o.gpio_o[i];
        st_nxt.poe[i]        = per_o.gpio_oe[i];
        st_nxt.pin.gpio_i[i] = st.flt[i];
      end else begin
        st_nxt.po[i]  = 1'b0;
        st_nxt.poe[i] = 1'b0;
      end
    end

    // P2.0
    case (fnv[0])
      FN_ALT1: st_nxt.pin.uart_four_receive = st.flt[0]; // RQ10
      FN_ALT2: st_nxt.pin.timer_two_external_input = st.flt[0]; // RQ10
      FN_ALT3: begin
        st_nxt.po[0]  = per_o.crystal_clock_output; // RQ10
        st_nxt.poe[0] = 1'b1;
      end
      default: ;
    endcase

    // P2.1; code 3 leaves the pad undriven
    case (fnv[1])
      FN_ALT1: begin
        st_nxt.po[1]  = per_o.uart_four_transmit; // RQ9
        st_nxt.poe[1] = 1'b1;
      end
      FN_ALT2: st_nxt.pin.timer_zero_external_input = st.flt[1]; // RQ9
      default: ;
    endcase

    // P2.2 and P2.3
    if (fnv[2] == FN_ALT1) st_nxt.pin.uart_three_receive = st.flt[2]; // RQ8
    if (fnv[3] == FN_ALT1) begin
      st_nxt.po[3]  = per_o.uart_three_transmit; // RQ8
      st_nxt.poe[3] = 1'b1;
    end

    // P2.4: an infrared receiver must hand over demodulated data
    if (fnv[4] == FN_ALT1) st_nxt.pin.uart_two_receive = st.flt[4]; // RQ7

    // P2.5: carrier bursts while the line is low, dark while idle high
    if (fnv[5] == FN_ALT1) begin
      st_nxt.poe[5] = 1'b1;
      if (st.port2_function_select[5][FS_CARRIER_BIT]) begin
        st_nxt.po[5] = ~per_o.uart_two_transmit & st.car; // RQ6
      end else begin
        st_nxt.po[5] = per_o.uart_two_transmit; // RQ6
      end
    end

    // P9.1: calibration interface has priority over the select register
    if (scal) begin
      st_nxt.po[6]     = per_o.sda_o; // RQ3
      st_nxt.poe[6]    = per_o.sda_oe;
      st_nxt.pin.sda_i = st.flt[6];
    end else if (fnv[6] == FN_ALT1) begin
      st_nxt.po[6]  = per_o.timer_a_channel_one_pin_o; // RQ1
      st_nxt.poe[6] = per_o.timer_a_channel_one_pin_oe;
      st_nxt.pin.timer_a_channel_one_pin_i = st.flt[6];
    end else if (fnv[6] == FN_ALT2) begin
      // width is the source's duty; the pulse is passed as is
      st_nxt.pin.reference_second_pulse_input = st.flt[6]; // RQ2
    end

    // P9.2
    if (scal) begin
      st_nxt.po[7]     = per_o.scl_o; // RQ4
      st_nxt.poe[7]    = per_o.scl_oe;
      st_nxt.pin.scl_i = st.flt[7];
    end else if (fnv[7] == FN_ALT1) begin
      st_nxt.po[7]  = per_o.timer_a_channel_two_pin_o; // RQ5
      st_nxt.poe[7] = per_o.timer_a_channel_two_pin_oe;
      st_nxt.pin.timer_a_channel_two_pin_i = st.flt[7];
    end

    st_nxt.region = pfs_region(mem_space, mem_addr); // RQ12 RQ13 RQ14
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= ST_RST;
    end else begin
      st <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_rdata  = st.rdata;
  assign pad_o      = st.po;
  assign pad_oe     = st.poe;
  assign sys_rst_b  = ~st.srst;
  assign per_i      = st.pin;
  assign mem_region = st.region;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_sda_route;
    st.protection_control_zero[PROT_SCAL_EN_BIT] |=>
      pad_o[6] == $past(per_o.sda_o) && pad_oe[6] == $past(per_o.sda_oe);
  endproperty
  a_sda_route: assert property (p_sda_route) else $error("P9.1 not carrying serial data"); // RQ3

  property p_scl_route;
    st.protection_control_zero[PROT_SCAL_EN_BIT] |=>
      pad_o[7] == $past(per_o.scl_o) && per_i.scl_i == $past(st.flt[7]);
  endproperty
  a_scl_route: assert property (p_scl_route) else $error("P9.2 not carrying serial clock"); // RQ4

  property p_ta1_route;
    !st.protection_control_zero[PROT_SCAL_EN_BIT] && fnv[6] == FN_ALT1 |=>
      pad_oe[6] == $past(per_o.timer_a_channel_one_pin_oe) && per_i.sda_i;
  endproperty
  a_ta1_route: assert property (p_ta1_route) else $error("P9.1 timer A routing wrong"); // RQ1

  property p_ta2_route;
    !st.protection_control_zero[PROT_SCAL_EN_BIT] && fnv[7] == FN_ALT1 |=>
      pad_o[7] == $past(per_o.timer_a_channel_two_pin_o);
  endproperty
  a_ta2_route: assert property (p_ta2_route) else $error("P9.2 timer A routing wrong"); // RQ5

  property p_tx2_plain;
    fnv[5] == FN_ALT1 && !st.port2_function_select[5][FS_CARRIER_BIT] |=>
      pad_oe[5] && pad_o[5] == $past(per_o.uart_two_transmit);
  endproperty
  a_tx2_plain: assert property (p_tx2_plain) else $error("P2.5 transmit routing wrong"); // RQ6

  property p_tx3_route;
    fnv[3] == FN_ALT1 |=> pad_oe[3] && pad_o[3] == $past(per_o.uart_three_transmit);
  endproperty
  a_tx3_route: assert property (p_tx3_route) else $error("P2.3 transmit routing wrong"); // RQ8

  property p_t0_route;
    fnv[1] == FN_ALT2 |=> !pad_oe[1] && per_i.timer_zero_external_input == $past(st.flt[1]);
  endproperty
  a_t0_route: assert property (p_t0_route) else $error("P2.1 timer input routing wrong"); // RQ9

  property p_osc_route;
    fnv[0] == FN_ALT3 |=> pad_oe[0] && pad_o[0] == $past(per_o.crystal_clock_output);
  endproperty
  a_osc_route: assert property (p_osc_route) else $error("P2.0 clock output wrong"); // RQ10

  property p_rx2_idle;
    fnv[4] != FN_ALT1 |=> per_i.uart_two_receive;
  endproperty
  a_rx2_idle: assert property (p_rx2_idle) else $error("unrouted receive not idle"); // RQ15

  property p_rst_hold;
    $fell(sys_rst_b) |-> $past(st.rcnt) == 17'(RST_HOLD_CYCLES - 1) && !$past(st.flt[8]);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("system reset before hold time"); // RQ11

  property p_sfr_map;
    mem_space == SP_DIRECT && mem_addr[15:7] == 9'h001 |=> mem_region == RG_SFR;
  endproperty
  a_sfr_map: assert property (p_sfr_map) else $error("upper direct space not SFR"); // RQ12

  property p_tx4_route;
    fnv[1] == FN_ALT1 |=>
      pad_oe[1] && pad_o[1] == $past(per_o.uart_four_transmit);
  endproperty
  a_tx4_route: assert property (p_tx4_route) else $error("P2.1 UART4 out wrong"); // RQ9

  property p_rx4_route;
    fnv[0] == FN_ALT1 |=>
      !pad_oe[0] && per_i.uart_four_receive == $past(st.flt[0]);
  endproperty
  a_rx4_route: assert property (p_rx4_route) else $error("P2.0 UART4 in wrong"); // RQ10

  property p_t2_route;
    fnv[0] == FN_ALT2 |=>
      !pad_oe[0] && per_i.timer_two_external_input == $past(st.flt[0]);
  endproperty
  a_t2_route: assert property (p_t2_route) else $error("P2.0 timer input wrong"); // RQ10

  property p_rx3_route;
    fnv[2] == FN_ALT1 |=>
      !pad_oe[2] && per_i.uart_three_receive == $past(st.flt[2]);
  endproperty
  a_rx3_route: assert property (p_rx3_route) else $error("P2.2 UART3 in wrong"); // RQ8

  property p_gpio2_route;
    fnv[2] == FN_GPIO |=>
      pad_oe[2] == $past(per_o.gpio_oe[2]) && per_i.gpio_i[2] == $past(st.flt[2]);
  endproperty
  a_gpio2_route: assert property (p_gpio2_route) else $error("P2.2 GPIO wrong"); // RQ8

  property p_rx2_route;
    fnv[4] == FN_ALT1 |=>
      !pad_oe[4] && per_i.uart_two_receive == $past(st.flt[4]);
  endproperty
  a_rx2_route: assert property (p_rx2_route) else $error("P2.4 UART2 in wrong"); // RQ7

  property p_tx2_dark;
    fnv[5] == FN_ALT1 && st.port2_function_select[5][FS_CARRIER_BIT] && per_o.uart_two_transmit |=>
      pad_oe[5] && !pad_o[5];
  endproperty
  a_tx2_dark: assert property (p_tx2_dark) else $error("P2.5 carrier while idle"); // RQ6

  property p_ref_route;
    !scal && fnv[6] == FN_ALT2 |=>
      !pad_oe[6] && per_i.reference_second_pulse_input == $past(st.flt[6]);
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("P9.1 pulse input wrong"); // RQ2

  property p_rst_free;
    st.flt[8] |=>
      sys_rst_b;
  endproperty
  a_rst_free: assert property (p_rst_free) else $error("system reset without low pin"); // RQ11

  property p_iram_hi_map;
    mem_space == SP_INDIRECT && mem_addr[15:7] == 9'h001 |=>
      mem_region == RG_IRAM_HI;
  endproperty
  a_iram_hi_map: assert property (p_iram_hi_map) else $error("upper indirect space not RAM"); // RQ12

  property p_code_map;
    mem_space == SP_CODE |=>
      mem_region == RG_CODE;
  endproperty
  a_code_map: assert property (p_code_map) else $error("program space not flash"); // RQ14

endmodule : pfs_top

`default_nettype wire

/* common/pfs_pkg.sv */
// package: types, map offsets and timing constants of the pin function select block
//
// Operation
// RQ1: P9.1 is fast GPIO or timer A channel one, per port9_function_select.
// RQ2: P9.1 may take a one-second reference pulse; the source keeps that width.
// RQ3: calibration interface enable puts its data line onto P9.1.
// RQ4: calibration interface enable puts its clock line onto P9.2.
// RQ5: otherwise P9.2 is fast GPIO or timer A channel two.
// RQ6: P2.5 is GPIO or UART2 transmit, optionally as a 38 kHz carrier.
// RQ7: P2.4 is GPIO or UART2 receive; infrared input arrives demodulated.
// RQ8: P2.3 and P2.2 are GPIO or UART3 transmit and receive.
// RQ9: P2.1 is GPIO, UART4 transmit or timer 0 external input.
// RQ10: P2.0 is GPIO, UART4 receive, timer 2 input or crystal clock output.
// RQ11: reset pin is active low; system reset only after 5 ms low.
// RQ12: internal RAM is 256 bytes; upper 128 share the SFR addresses.
// RQ13: 4 KB extended RAM and peripherals fill data space 0000h to FFFFh.
// RQ14: 64 KB flash maps the whole program space 0000h to FFFFh.
// RQ15: unrouted peripheral inputs see a fixed inactive level.
`default_nettype none

package pfs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned RST_HOLD_MS  = 5;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned CARRIER_HZ   = 38000;
  localparam int unsigned CAR_HALF     = CLK_HZ / (2 * CARRIER_HZ);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]       ADR_PORT9_FUNCTION_SELECT   = 8'hAD;
  localparam logic [15:0]      ADR_PROTECTION_CONTROL_ZERO = 16'h2D00;
  // index i is port 2 pin i
  localparam logic [5:0][15:0] ADR_PORT2_FUNCTION_SELECT   =
    {16'h28CE, 16'h28CD, 16'h28CC, 16'h28CB, 16'h28CA, 16'h28C9};
  localparam logic [7:0]       RST_FS                      = 8'h00;
  localparam logic [7:0]       RST_PROT                    = 8'h00;

  localparam logic [3:0] RI_P9   = 4'h0;
  localparam logic [3:0] RI_P2_0 = 4'h1;
  localparam logic [3:0] RI_PROT = 4'h7;
  localparam logic [3:0] RI_NONE = 4'hF;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned P9_PIN1_LSB      = 0;
  localparam int unsigned P9_PIN2_LSB      = 2;
  localparam int unsigned FS_FN_LSB        = 0;
  localparam int unsigned FS_CARRIER_BIT   = 2;
  localparam int unsigned PROT_SCAL_EN_BIT = 6;

  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_ALT3 = 2'h3;

  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam int unsigned IRAM_BYTES = 256;
  localparam int unsigned IRAM_LO    = 128;
  localparam int unsigned XRAM_BYTES = 4096;
  localparam int unsigned CODE_BYTES = 65536;

  typedef enum logic [1:0] {SP_DIRECT, SP_INDIRECT, SP_XDATA, SP_CODE} pfs_space_t;
  typedef enum logic [2:0] {
    RG_NONE, RG_IRAM_LO, RG_IRAM_HI, RG_SFR, RG_XRAM, RG_PERIPH, RG_CODE
  } pfs_region_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        sfr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pfs_bus_req_t;

  typedef struct packed {
    logic [7:0] gpio_o;
    logic [7:0] gpio_oe;
    logic       timer_a_channel_one_pin_o;
    logic       timer_a_channel_one_pin_oe;
    logic       timer_a_channel_two_pin_o;
    logic       timer_a_channel_two_pin_oe;
    logic       sda_o;
    logic       sda_oe;
    logic       scl_o;
    logic       scl_oe;
    logic       uart_two_transmit;
    logic       uart_three_transmit;
    logic       uart_four_transmit;
    logic       crystal_clock_output;
  } pfs_per_out_t;

  typedef struct packed {
    logic [7:0] gpio_i;
    logic       timer_a_channel_one_pin_i;
    logic       timer_a_channel_two_pin_i;
    logic       reference_second_pulse_input;
    logic       sda_i;
    logic       scl_i;
    logic       uart_two_receive;
    logic       uart_three_receive;
    logic       uart_four_receive;
    logic       timer_zero_external_input;
    logic       timer_two_external_input;
  } pfs_per_in_t;

  // idle: uart lines and serial lines high, timers and pulses low
  localparam pfs_per_in_t PIN_IDLE = '{
    sda_i: 1'b1, scl_i: 1'b1, uart_two_receive: 1'b1,
    uart_three_receive: 1'b1, uart_four_receive: 1'b1, default: '0};

  localparam logic [8:0] SYNC_RST = 9'h1FF;

  typedef struct packed {
    logic [7:0]      port9_function_select;
    logic [5:0][7:0] port2_function_select;
    logic [7:0]      protection_control_zero;
    logic [8:0]      sy1;
    logic [8:0]      sy2;
    logic [8:0]      sy3;
    logic [8:0]      flt;
    logic [16:0]     rcnt;
    logic            srst;
    logic [8:0]      ccnt;
    logic            car;
    logic [7:0]      po;
    logic [7:0]      poe;
    pfs_per_in_t     pin;
    logic [7:0]      rdata;
    pfs_region_t     region;
  } pfs_state_t;

  localparam pfs_state_t ST_RST = '{
    port9_function_select: RST_FS, port2_function_select: {6{RST_FS}},
    protection_control_zero: RST_PROT, sy1: SYNC_RST, sy2: SYNC_RST,
    sy3: SYNC_RST, flt: SYNC_RST, pin: PIN_IDLE, region: RG_NONE,
    default: '0};

endpackage : pfs_pkg

`default_nettype wire

/* verif/pfs_far_model.sv */
// far side model: outside parties on the pads and the reset pin source
`timescale 1ns/1ps
`default_nettype none

module pfs_far_model (
  // clock
  input  wire logic       clk,
  // pads
  input  wire logic [7:0] pad_o,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] ext_lvl,
  output logic [7:0]      pad_i,
  // reset source
  input  wire logic [7:0] rst_len,
  input  wire logic       rst_go,
  output logic            reset_active_low
);
  int unsigned cnt_r = 0;

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  // outside drives only released pads; ir data and pulses arrive clean
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_i[i] = pad_oe[i] ? pad_o[i] : ext_lvl[i];
    end
  end

  // ----------------------------------------------------------------
  // reset pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_go)
      cnt_r <= rst_len;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  end
  assign reset_active_low = (cnt_r == 0);

endmodule : pfs_far_model

`default_nettype wire

/* verif/testbench.sv */
// self-checking bench of the pin function select block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pfs_pkg::*;

  typedef struct packed {
    logic        sfr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rexp;
  } pfs_row_t;

  localparam int unsigned HOLD = 16;

  logic         clk       = 1'b0;
  logic         rst_b     = 1'b0;
  pfs_bus_req_t bus_req   = '0;
  logic [7:0]   ext_lvl   = 8'h00;
  logic [7:0]   rst_len   = 8'h00;
  logic         rst_go    = 1'b0;
  pfs_per_out_t per_o     = '0;
  pfs_space_t   mem_space = SP_DIRECT;
  logic [15:0]  mem_addr  = 16'h0000;
  logic [7:0]   bus_rdata;
  logic [7:0]   pad_i;
  logic [7:0]   pad_o;
  logic [7:0]   pad_oe;
  logic         reset_active_low;
  logic         sys_rst_b;
  pfs_per_in_t  per_i;
  pfs_region_t  mem_region;
  logic [7:0]   d;
  int           failures  = 0;
  int           checked   = 0;
  int           cycles    = 0;
  int           n;
  int           k0;
  int           k1;
  pfs_row_t     rows [10] = '{
    '{1'b1, 16'h00AD, 8'hA5, 8'hA5}, '{1'b0, 16'h28C9, 8'h5A, 8'h5A},
    '{1'b0, 16'h28CA, 8'h3C, 8'h3C}, '{1'b0, 16'h28CB, 8'hC3, 8'hC3},
    '{1'b0, 16'h28CC, 8'h0F, 8'h0F}, '{1'b0, 16'h28CD, 8'hF0, 8'hF0},
    '{1'b0, 16'h28CE, 8'h96, 8'h96}, '{1'b0, 16'h2D00, 8'h69, 8'h69},
    '{1'b0, 16'h28C8, 8'hFF, 8'h00}, '{1'b1, 16'h00AE, 8'hFF, 8'h00}};

  pfs_top #(.RST_HOLD_CYCLES(HOLD)) dut_u (
    .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .reset_active_low(reset_active_low),
    .sys_rst_b(sys_rst_b), .per_o(per_o), .per_i(per_i), .mem_space(mem_space),
    .mem_addr(mem_addr), .mem_region(mem_region));

  pfs_far_model far_u (
    .clk(clk), .pad_o(pad_o), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .pad_i(pad_i),
    .rst_len(rst_len), .rst_go(rst_go), .reset_active_low(reset_active_low));

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic sfr, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, sfr: sfr, addr: a, wdata: v};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic sfr, input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, sfr: sfr, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd

  task automatic sel(input int pin, input logic [7:0] v);
    wr(1'b0, ADR_PORT2_FUNCTION_SELECT[pin], v);
  endtask : sel

  task automatic mm(input pfs_space_t s, input logic [15:0] a, input pfs_region_t e);
    @(posedge clk);
    mem_space <= s;
    mem_addr  <= a;
    cyc(1);
    chk(mem_region, e, "region");
  endtask : mm

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(3);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].sfr, rows[i].addr, d);
      chk(d, 8'h00, "reset value");
      wr(rows[i].sfr, rows[i].addr, rows[i].wdata);
      rd(rows[i].sfr, rows[i].addr, d);
      chk(d, rows[i].rexp, "read back");
    end
    cyc(1);
    chk(bus_rdata, 8'h00, "read data one cycle only");
    $display("test registers done");
    // outputs: gpio drives ones, alternates zeros, then ones
    wr(1'b0, ADR_PROTECTION_CONTROL_ZERO, 8'h00);
    for (int p = 0; p < 6; p++) sel(p, 8'h00);
    wr(1'b1, 16'h00AD, 8'h00);
    per_o <= '{gpio_o: 8'hFF, gpio_oe: 8'hFF, timer_a_channel_one_pin_oe: 1'b1,
               timer_a_channel_two_pin_oe: 1'b1, sda_oe: 1'b1, scl_oe: 1'b1, default: '0};
    cyc(2);
    chk({pad_o, pad_oe}, 16'hFFFF, "gpio pads");
    sel(0, 8'h03);
    sel(1, 8'h01);
    sel(3, 8'h01);
    sel(5, 8'h01);
    wr(1'b1, 16'h00AD, 8'h05);
    cyc(2);
    chk({pad_o, pad_oe}, 16'h14FF, "alternate outputs low");
    per_o.uart_two_transmit <= 1'b1;
    per_o.uart_three_transmit <= 1'b1;
    per_o.uart_four_transmit <= 1'b1;
    per_o.crystal_clock_output <= 1'b1;
    per_o.timer_a_channel_one_pin_o <= 1'b1;
    per_o.timer_a_channel_two_pin_o <= 1'b1;
    cyc(2);
    chk({pad_o, pad_oe}, 16'hFFFF, "alternate outputs high");
    chk(per_i.gpio_i, 8'h14, "gpio in");
    // calibration interface takes over both fast pins
    wr(1'b0, ADR_PROTECTION_CONTROL_ZERO, 8'h40);
    cyc(2);
    chk({pad_o[7:6], pad_oe[7:6]}, 4'h3, "serial lines out");
    per_o.sda_oe <= 1'b0;
    per_o.scl_oe <= 1'b0;
    ext_lvl <= 8'h00;
    cyc(6);
    chk({pad_oe[7:6], per_i.sda_i, per_i.scl_i, per_i.timer_a_channel_one_pin_i}, 5'h00, "serial in");
    $display("test outputs done");
    // inputs: receives idle high, timers idle low
    wr(1'b0, ADR_PROTECTION_CONTROL_ZERO, 8'h00);
    per_o <= '0;
    sel(0, 8'h01);
    sel(1, 8'h02);
    sel(2, 8'h01);
    sel(4, 8'h01);
    wr(1'b1, 16'h00AD, 8'h06);
    for (int t = 0; t < 2; t++) begin
      ext_lvl <= (t == 0) ? 8'hC2 : 8'h3D;
      cyc(6);
      chk({per_i.uart_four_receive, per_i.timer_zero_external_input, per_i.uart_three_receive,
           per_i.uart_two_receive, per_i.reference_second_pulse_input, per_i.timer_a_channel_two_pin_i},
          (t == 0) ? 6'h13 : 6'h2C, "routed inputs");
      chk({per_i.timer_two_external_input, per_i.timer_a_channel_one_pin_i, per_i.sda_i, per_i.scl_i},
          4'h3, "unrouted idle");
    end
    sel(0, 8'h02);
    wr(1'b1, 16'h00AD, 8'h01);
    ext_lvl <= 8'h41;
    cyc(6);
    chk({per_i.timer_two_external_input, per_i.timer_a_channel_one_pin_i, per_i.uart_four_receive},
        3'h7, "timer inputs");
    $display("test inputs done");
    // carrier while the transmit line is low, none while idle
    per_o.uart_two_transmit <= 1'b0;
    sel(5, 8'h05);
    for (int t = 0; t < 2; t++) begin
      cyc(2);
      n = 0;
      d[0] = pad_o[5];
      repeat (700) begin
        cyc(1);
        if (pad_o[5] !== d[0]) n++;
        d[0] = pad_o[5];
      end
      chk((t == 0) ? (n >= 2 && n <= 3) : (n == 0 && pad_o[5] === 1'b0), 1'b1, "carrier");
      per_o.uart_two_transmit <= 1'b1;
    end
    $display("test carrier done");
    // reset pin: short low ignored, long low asserts then releases
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      rst_len <= (t == 0) ? 8'h08 : 8'h28;
      rst_go  <= 1'b1;
      @(posedge clk);
      rst_go  <= 1'b0;
      k0 = -1;
      k1 = -1;
      for (int c = 0; c < 70; c++) begin
        cyc(1);
        if (sys_rst_b !== 1'b1 && k0 < 0) k0 = c;
        if (sys_rst_b !== 1'b1) k1 = c;
      end
      if (t == 0)
        chk(k0 == -1, 1'b1, "short low ignored");
      else
        chk(k0 >= HOLD && k0 <= HOLD + 7 && k1 >= 40 && k1 <= 47, 1'b1, "long low");
    end
    $display("test reset pin done");
    mm(SP_DIRECT, 16'h007F, RG_IRAM_LO);
    mm(SP_DIRECT, 16'h0080, RG_SFR);
    mm(SP_INDIRECT, 16'h00FF, RG_IRAM_HI);
    mm(SP_INDIRECT, 16'h0100, RG_NONE);
    mm(SP_XDATA, 16'h0FFF, RG_XRAM);
    mm(SP_XDATA, 16'h1000, RG_PERIPH);
    mm(SP_XDATA, 16'hFFFF, RG_PERIPH);
    mm(SP_CODE, 16'hFFFF, RG_CODE);
    $display("test memory map done");
    @(posedge clk);
    rst_b <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    rd(1'b1, 16'h00AD, d);
    chk({d, pad_oe}, 16'h0000, "second reset");
    $display("test second reset done");
    close_out();
  end

endmodule : testbench

`default_nettype wire
